//--- pkg/alu_pkg.sv
// alu_pkg: constants shared by the accumulator alu files
package alu_pkg;
  localparam int unsigned DATA_W   = 8;
  // states per instruction, one mclk each
  localparam logic [3:0]  ST_REG   = 4'h4;
  localparam logic [3:0]  ST_MEM   = 4'h7;
  localparam logic [3:0]  ST_IMM   = 4'h7;
  localparam logic [3:0]  ST_INR   = 4'h5;
  localparam logic [3:0]  ST_INRM  = 4'hA;
  localparam logic [3:0]  ST_PAIR  = 4'h5;
  localparam logic [3:0]  ST_DAD   = 4'hA;
  localparam logic [3:0]  ST_DAA   = 4'h4;
  // register field codes
  localparam logic [2:0]  IDX_H    = 3'h4;
  localparam logic [2:0]  IDX_L    = 3'h5;
  localparam logic [2:0]  IDX_MEM  = 3'h6;
  localparam logic [2:0]  IDX_A    = 3'h7;
  localparam logic [1:0]  PAIR_HL  = 2'h2;
  localparam logic [1:0]  PAIR_SP  = 2'h3;
  // operation field of the arithmetic/logic group
  localparam logic [2:0]  OP_ADD   = 3'h0;
  localparam logic [2:0]  OP_ADC   = 3'h1;
  localparam logic [2:0]  OP_SUB   = 3'h2;
  localparam logic [2:0]  OP_SBB   = 3'h3;
  localparam logic [2:0]  OP_AND   = 3'h4;
  localparam logic [2:0]  OP_XOR   = 3'h5;
  localparam logic [2:0]  OP_OR    = 3'h6;
  localparam logic [2:0]  OP_CMP   = 3'h7;
  localparam logic [7:0]  OPC_DAA  = 8'h27;
  localparam logic [3:0]  BCD_MAX  = 4'h9;
  localparam logic [3:0]  BCD_FIX  = 4'h6;
  // flag byte layout
  localparam int unsigned FL_CY    = 0;
  localparam int unsigned FL_P     = 2;
  localparam int unsigned FL_AC    = 4;
  localparam int unsigned FL_Z     = 6;
  localparam int unsigned FL_S     = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h02;
  localparam logic [15:0] SP_RST   = 16'h0000;
  typedef enum logic [1:0] {
    ALU_IDLE = 2'b00,
    ALU_RUN  = 2'b01
  } alu_state_e;
endpackage : alu_pkg

//--- verilog/alu_flagcalc.sv
// alu_flagcalc: zero, sign and parity of a result byte
module alu_flagcalc
  import alu_pkg::*;
#(
  parameter int unsigned W = alu_pkg::DATA_W
)
(
  // result in
  input  wire logic [W-1:0] res,
  // flags out
  output logic              zero,
  output logic              sign,
  output logic              parity
);
  if (W < 2)
  begin : g_bad_w
    $error("alu_flagcalc needs at least two bits");
  end
  assign zero   = (res == '0);
  assign sign   = res[W-1];
  assign parity = ~^res;
endmodule : alu_flagcalc

//--- verilog/alu_regfile.sv
// alu_regfile: register array with registered contents and two write ports
module alu_regfile
  import alu_pkg::*;
#(
  parameter int unsigned W     = alu_pkg::DATA_W,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
)
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // low write port, wins on a clash
  input  wire logic              we_lo,
  input  wire logic [AW-1:0]     addr_lo,
  input  wire logic [W-1:0]      d_lo,
  // high write port
  input  wire logic              we_hi,
  input  wire logic [AW-1:0]     addr_hi,
  input  wire logic [W-1:0]      d_hi,
  // all entries, straight from the flops
  output logic [DEPTH*W-1:0]     q
);
  logic [W-1:0] mem_reg [DEPTH];
  if (DEPTH != (1 << AW))
  begin : g_bad_depth
    $error("alu_regfile depth must equal two to the address width");
  end
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        mem_reg[i] <= '0;
      else if (we_lo && (addr_lo == AW'(i)))
        mem_reg[i] <= d_lo;
      else if (we_hi && (addr_hi == AW'(i)))
        mem_reg[i] <= d_hi;
    end
    assign q[i*W +: W] = mem_reg[i];
  end
endmodule : alu_regfile

//--- verilog/alu_core.sv
// alu_core: sequencing and datapath of the accumulator arithmetic logic unit
module alu_core
  import alu_pkg::*;
#(
  parameter int unsigned DW = alu_pkg::DATA_W
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // instruction command
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  mem_rdata,
  // register load while idle
  input  wire logic        ld_we,
  input  wire logic [2:0]  ld_sel,
  input  wire logic [7:0]  ld_data,
  input  wire logic        sp_we,
  input  wire logic [15:0] sp_data,
  // status
  output logic             busy,
  output logic             done,
  output logic             illegal,
  output logic [7:0]       flags,
  // memory write-back
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  // register view
  output logic [7:0]       acc,
  output logic [15:0]      hl,
  output logic [15:0]      sp,
  output logic [63:0]      regs
);
  import alu_pkg::*;

  if (DW != 8)
  begin : g_bad_dw
    $error("alu_core serves an 8-bit datapath only");
  end

  function automatic logic [3:0] dec_states(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op[7:6] == 2'b10)
      n = (op[2:0] == IDX_MEM) ? ST_MEM : ST_REG;
    else if (op[7:6] == 2'b11 && op[2:0] == 3'h6)
      n = ST_IMM;
    else if (op == OPC_DAA)
      n = ST_DAA;
    else if (op[7:6] == 2'b00 && op[2:1] == 2'b10)
      n = (op[5:3] == IDX_MEM) ? ST_INRM : ST_INR;
    else if (op[7:6] == 2'b00 && op[2:0] == 3'h3)
      n = ST_PAIR;
    else if (op[7:6] == 2'b00 && op[3:0] == 4'h9)
      n = ST_DAD;
    return n;
  endfunction : dec_states

  alu_state_e  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  op_reg, opnd_reg;
  logic        busy_reg, done_reg, illegal_reg, mem_we_reg;
  logic [7:0]  mem_wdata_reg, flags_reg, fl_next;
  logic [15:0] sp_reg, sp_next;
  logic [63:0] rf_q;
  logic        f_z, f_s, f_p;

  // command decode on the incoming opcode
  wire       idle      = (state_reg == ALU_IDLE);
  wire       take      = start && idle;
  wire [3:0] in_states = dec_states(opcode);
  wire       accept    = take && (in_states != 4'h0);
  wire       commit    = (state_reg == ALU_RUN) && (cnt_reg == 4'h1);
  wire [2:0] in_src    = (opcode[7:6] == 2'b00) ? opcode[5:3] : opcode[2:0];
  wire       in_imm    = (opcode[7:6] == 2'b11);
  // operand captured once, so later register loads cannot disturb it
  wire [7:0] in_opnd   = in_imm ? byte2 :
                         (in_src == IDX_MEM) ? mem_rdata :
                         rf_q[in_src*8 +: 8];

  // latched instruction classes
  wire [2:0] grp     = op_reg[5:3];
  wire       is_alu  = op_reg[7];
  wire       is_daa  = (op_reg == OPC_DAA);
  wire       low_grp = (op_reg[7:6] == 2'b00) && !is_daa;
  wire       is_inr  = low_grp && (op_reg[2:0] == 3'h4);
  wire       is_dcr  = low_grp && (op_reg[2:0] == 3'h5);
  wire       is_inx  = low_grp && (op_reg[3:0] == 4'h3);
  wire       is_dcx  = low_grp && (op_reg[3:0] == 4'hB);
  wire       is_dad  = low_grp && (op_reg[3:0] == 4'h9);
  wire       is_byte = is_inr || is_dcr;

  wire [7:0] acc_v = rf_q[IDX_A*8 +: 8];
  wire       cy_v  = flags_reg[FL_CY];
  wire       ac_v  = flags_reg[FL_AC];

  // pair selection
  wire [1:0]  rp       = op_reg[5:4];
  wire [2:0]  rp_hi    = {rp, 1'b0};
  wire [2:0]  rp_lo    = {rp, 1'b1};
  wire [15:0] pair_val = (rp == PAIR_SP) ? sp_reg :
                         {rf_q[rp_hi*8 +: 8], rf_q[rp_lo*8 +: 8]};
  wire [15:0] hl_val   = {rf_q[IDX_H*8 +: 8], rf_q[IDX_L*8 +: 8]};
  wire [15:0] pair_nx  = is_dcx ? (pair_val - 16'h0001)
                                : (pair_val + 16'h0001);
  wire [16:0] dad_sum  = {1'b0, hl_val} + {1'b0, pair_val};

  // shared adder: subtraction adds the complement, carry out inverted to borrow
  wire       is_sub = is_alu && (grp == OP_SUB || grp == OP_SBB || grp == OP_CMP);
  wire       use_cy = is_alu && (grp == OP_ADC || grp == OP_SBB);
  wire [7:0] ad_a   = is_alu ? acc_v : opnd_reg;
  wire [7:0] ad_b   = is_alu ? (is_sub ? ~opnd_reg : opnd_reg)
                             : (is_dcr ? 8'hFF : 8'h00);
  wire       ad_c   = is_alu ? (use_cy ? (cy_v ^ is_sub) : is_sub)
                             : is_inr;
  wire [8:0] ad_sum = {1'b0, ad_a} + {1'b0, ad_b} + {8'h00, ad_c};
  wire [4:0] ad_lo  = {1'b0, ad_a[3:0]} + {1'b0, ad_b[3:0]} + {4'h0, ad_c};
  wire       ad_cy  = ad_sum[8] ^ is_sub;

  wire [7:0] and_v = acc_v & opnd_reg;
  wire [7:0] xor_v = acc_v ^ opnd_reg;
  wire [7:0] or_v  = acc_v | opnd_reg;

  // decimal adjust in two steps
  wire       daa_lo = (acc_v[3:0] > BCD_MAX) || ac_v;
  wire [8:0] daa_t  = {1'b0, acc_v} + (daa_lo ? {5'h00, BCD_FIX} : 9'h000);
  wire       daa_hi = (daa_t[7:4] > BCD_MAX) || daa_t[8] || cy_v;
  wire [7:0] daa_v  = daa_t[7:0] + (daa_hi ? {BCD_FIX, 4'h0} : 8'h00);

  wire [7:0] res8 = is_daa ? daa_v :
                    !is_alu ? ad_sum[7:0] :
                    (grp == OP_AND) ? and_v :
                    (grp == OP_XOR) ? xor_v :
                    (grp == OP_OR)  ? or_v  :
                    ad_sum[7:0];

  alu_flagcalc #(
    .W      (8)
  ) u_flags (
    .res    (res8),
    .zero   (f_z),
    .sign   (f_s),
    .parity (f_p)
  );

  // flag update
  wire is_logic = is_alu && (grp == OP_AND || grp == OP_XOR || grp == OP_OR);
  // the register/memory and sets aux carry to the OR of both operands' bit 3; the immediate form clears it
  wire and_rm   = is_alu && (grp == OP_AND) && !op_reg[6];
  wire cy_n     = is_daa ? daa_hi :
                  is_dad ? dad_sum[16] :
                  is_logic ? 1'b0 :
                  is_alu ? ad_cy : cy_v;
  wire ac_n     = is_daa ? (acc_v[3:0] > BCD_MAX) :
                  and_rm ? (acc_v[3] | opnd_reg[3]) :
                  is_logic ? 1'b0 :
                  ad_lo[4];
  wire sets_zsp = is_alu || is_byte || is_daa;

  always_comb
  begin
    fl_next        = flags_reg;
    fl_next[FL_CY] = cy_n;
    if (sets_zsp)
    begin
      fl_next[FL_Z]  = f_z;
      fl_next[FL_S]  = f_s;
      fl_next[FL_P]  = f_p;
      fl_next[FL_AC] = ac_n;
    end
  end

  // register writes at the final state; register loads while idle share the low port
  wire       dst_mem = is_byte && (op_reg[5:3] == IDX_MEM);
  wire       w8_en   = commit && (is_daa || (is_alu && grp != OP_CMP)
                                 || (is_byte && !dst_mem));
  wire [2:0] w8_sel  = is_byte ? op_reg[5:3] : IDX_A;
  wire       pw_en   = commit && (is_dad || ((is_inx || is_dcx) && rp != PAIR_SP));
  wire [1:0] pw_rp   = is_dad ? PAIR_HL : rp;
  wire [15:0] pw_val = is_dad ? dad_sum[15:0] : pair_nx;
  wire       ld_ok   = ld_we && idle && (ld_sel != IDX_MEM);
  wire       we_lo   = w8_en || pw_en || ld_ok;
  wire [2:0] addr_lo = pw_en ? {pw_rp, 1'b1} : (w8_en ? w8_sel : ld_sel);
  wire [7:0] d_lo    = pw_en ? pw_val[7:0] : (w8_en ? res8 : ld_data);
  wire       sp_inc  = commit && (is_inx || is_dcx) && (rp == PAIR_SP);

  alu_regfile #(
    .W       (8),
    .DEPTH   (8),
    .AW      (3)
  ) u_rf (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we_lo   (we_lo),
    .addr_lo (addr_lo),
    .d_lo    (d_lo),
    .we_hi   (pw_en),
    .addr_hi ({pw_rp, 1'b0}),
    .d_hi    (pw_val[15:8]),
    .q       (rf_q)
  );

  always_comb
  begin
    sp_next = sp_reg;
    if (sp_inc)
      sp_next = pair_nx;
    else if (sp_we && idle)
      sp_next = sp_data;
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ALU_IDLE:
      begin
        if (accept)
        begin
          state_next = ALU_RUN;
          cnt_next   = in_states - 4'h1;
        end
      end
      ALU_RUN:
      begin
        if (commit)
          state_next = ALU_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= ALU_IDLE;
      cnt_reg     <= 4'h0;
      op_reg      <= 8'h00;
      opnd_reg    <= 8'h00;
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      flags_reg   <= FLAGS_RST;
      sp_reg      <= SP_RST;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      busy_reg    <= (state_next == ALU_RUN);
      done_reg    <= commit;
      illegal_reg <= take && (in_states == 4'h0);
      sp_reg      <= sp_next;
      if (accept)
      begin
        op_reg   <= opcode;
        opnd_reg <= in_opnd;
      end
      if (commit)
        flags_reg <= fl_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end
    else
    begin
      mem_we_reg <= commit && dst_mem;
      if (commit && dst_mem)
        mem_wdata_reg <= res8;
    end
  end

  assign busy      = busy_reg;
  assign done      = done_reg;
  assign illegal   = illegal_reg;
  assign flags     = flags_reg;
  assign mem_we    = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;
  assign acc       = acc_v;
  assign hl        = hl_val;
  assign sp        = sp_reg;
  assign regs      = rf_q;

  wire go = start && idle && !ld_we;

  sequence s_four_states;
    ##1 busy_reg [*3] ##1 done_reg;
  endsequence

  property p_adi_sum;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'hC6 |-> ##7 done_reg && acc == 8'($past(acc, 7) + $past(byte2, 7));
  endproperty
  a_adi_sum: assert property (p_adi_sum) else $error("add immediate wrong");

  property p_adc_time;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode[7:3] == 5'b10001 && opcode[2:0] != IDX_MEM |-> s_four_states;
  endproperty
  a_adc_time: assert property (p_adc_time) else $error("adc register timing");

  property p_sbb_time;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode[7:3] == 5'b10011 && opcode[2:0] != IDX_MEM |-> s_four_states;
  endproperty
  a_sbb_time: assert property (p_sbb_time) else $error("sbb register timing");

  property p_inr_b;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'h04 |-> ##5 done_reg && regs[7:0] == 8'($past(regs[7:0], 5) + 8'h01)
      && flags[FL_CY] == $past(flags[FL_CY], 5);
  endproperty
  a_inr_b: assert property (p_inr_b) else $error("increment register wrong");

  property p_inr_mem;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'h34 |-> ##1 !mem_we [*8] ##1 !mem_we ##1 mem_we
      && mem_wdata == 8'($past(mem_rdata, 10) + 8'h01);
  endproperty
  a_inr_mem: assert property (p_inr_mem) else $error("memory increment wrong");

  property p_inx_flags;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode[7:6] == 2'b00 && opcode[3:0] == 4'h3 |-> ##5 done_reg
      && flags == $past(flags, 5);
  endproperty
  a_inx_flags: assert property (p_inx_flags) else $error("pair increment flags");

  property p_dad_hl;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'h29 |-> ##10 done_reg && hl == {$past(hl[14:0], 10), 1'b0}
      && flags[FL_CY] == $past(hl[15], 10) && flags[7:1] == $past(flags[7:1], 10);
  endproperty
  a_dad_hl: assert property (p_dad_hl) else $error("pair add wrong");

  property p_and_cy;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode[7:3] == 5'b10100 |-> ##[4:7] done_reg ##0 !flags[FL_CY];
  endproperty
  a_and_cy: assert property (p_and_cy) else $error("and left carry set");

  property p_xor_or_clear;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode[7] && (opcode[5:3] == OP_XOR || opcode[5:3] == OP_OR)
      && (!opcode[6] || opcode[2:0] == 3'h6)
      |-> ##[4:7] done_reg ##0 !flags[FL_CY] && !flags[FL_AC];
  endproperty
  a_xor_or_clear: assert property (p_xor_or_clear) else $error("carry not cleared");

  property p_cmp_imm;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'hFE |-> ##7 done_reg && acc == $past(acc, 7)
      && flags[FL_Z] == ($past(acc, 7) == $past(byte2, 7))
      && flags[FL_CY] == ($past(acc, 7) < $past(byte2, 7));
  endproperty
  a_cmp_imm: assert property (p_cmp_imm) else $error("compare wrong");

  property p_mem_time;
    @(posedge mclk) disable iff (!rst_n)
    go && opcode == 8'h86 |-> ##1 busy_reg [*6] ##1 done_reg;
  endproperty
  a_mem_time: assert property (p_mem_time) else $error("memory add timing");
endmodule : alu_core

//--- tb/alu_mem_model.sv
// memory byte at (H,L) as the instruction control would present it
module alu_mem_model
(
  // clock
  input  wire logic        mclk,
  // address and write-back from the unit
  input  wire logic [15:0] hl,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_wdata,
  // bench preset of the addressed byte
  input  wire logic        pre_we,
  input  wire logic [7:0]  pre_data,
  // operand back to the unit
  output logic [7:0]       mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the low address byte decodes; aliasing is harmless here
  logic [7:0] mem_reg [256];
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem_reg[hl[7:0]] <= mem_wdata;
    else if (pre_we)
      mem_reg[hl[7:0]] <= pre_data;
  end
  assign mem_rdata = mem_reg[hl[7:0]];
endmodule : alu_mem_model

//--- tb/alu_core_test.sv
// self-checking bench of the accumulator alu
module alu_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_pkg::*;
  logic mclk, rst_n, start, ld_we, sp_we, pre_we, busy, done, illegal, mem_we;
  logic [7:0] opcode, byte2, mem_rdata, ld_data, pre_data, flags, mem_wdata, acc;
  logic [2:0] ld_sel;
  logic [15:0] sp_data, hl, sp;
  logic [63:0] regs;
  int err_total, num_checks;
  alu_core alu_core_inst (.mclk(mclk), .rst_n(rst_n), .start(start), .opcode(opcode),
    .byte2(byte2), .mem_rdata(mem_rdata), .ld_we(ld_we), .ld_sel(ld_sel), .ld_data(ld_data),
    .sp_we(sp_we), .sp_data(sp_data), .busy(busy), .done(done), .illegal(illegal),
    .flags(flags), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc), .hl(hl), .sp(sp),
    .regs(regs));
  alu_mem_model alu_mem_model_inst (.mclk(mclk), .hl(hl), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .pre_we(pre_we), .pre_data(pre_data), .mem_rdata(mem_rdata));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // expected flag byte: S Z 0 AC 0 P 1 CY
  function automatic logic [7:0] ef(input logic [7:0] r, input logic a, c);
    return {r[7], r == 8'h00, 1'b0, a, 1'b0, ~^r, 1'b1, c};
  endfunction : ef
  task automatic chk8(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk16(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk16
  task automatic ld(input logic [2:0] s, input logic [7:0] d);
    @(posedge mclk);
    ld_we <= 1'b1;
    ld_sel <= s;
    ld_data <= d;
    @(posedge mclk);
    ld_we <= 1'b0;
  endtask : ld
  task automatic pre(input logic [7:0] d);
    @(posedge mclk);
    pre_we <= 1'b1;
    pre_data <= d;
    @(posedge mclk);
    pre_we <= 1'b0;
  endtask : pre
  // issue one instruction, count states up to done, check flags there
  task automatic op(input logic [7:0] o, b, n, fe);
    int cnt;
    @(posedge mclk);
    start <= 1'b1;
    opcode <= o;
    byte2 <= b;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    cnt = 1;
    while (done !== 1'b1 && cnt < 20)
    begin
      @(negedge mclk);
      cnt++;
    end
    chk8("states", n, 8'(cnt));
    chk8("flags", fe, flags);
  endtask : op
  task automatic t_reset;
    chk8("flags", FLAGS_RST, flags);
    chk8("acc", 8'h00, acc);
    chk16("sp", SP_RST, sp);
    chk8("busy", 8'h00, {7'h00, busy});
    for (int i = 0; i < 8; i++)
      ld(3'(i), 8'h11 * 8'(i + 1));
    @(negedge mclk);
    for (int i = 0; i < 8; i++)
      chk8("reg", (i == 6) ? 8'h00 : 8'h11 * 8'(i + 1), regs[8*i +: 8]);
    $display("test reset/fields finished");
  endtask : t_reset
  task automatic t_arith;
    ld(3'h4, 8'h00);
    ld(3'h5, 8'h20);
    ld(3'h7, 8'h3A);
    ld(3'h0, 8'h05);
    pre(8'h10);
    op(8'hC6, 8'hC6, 8'h07, ef(8'h00, 1, 1));
    op(8'h88, 8'h00, 8'h04, ef(8'h06, 0, 0));
    op(8'hCE, 8'hFF, 8'h07, ef(8'h05, 1, 1));
    op(8'h8E, 8'h00, 8'h07, ef(8'h16, 0, 0));
    op(8'h90, 8'h00, 8'h04, ef(8'h11, 1, 0));
    op(8'hD6, 8'h20, 8'h07, ef(8'hF1, 1, 1));
    op(8'h98, 8'h00, 8'h04, ef(8'hEB, 0, 0));
    op(8'hDE, 8'hEC, 8'h07, ef(8'hFF, 0, 1));
    op(8'h9E, 8'h00, 8'h07, ef(8'hEE, 1, 0));
    chk8("acc", 8'hEE, acc);
    op(8'h86, 8'h00, 8'h07, ef(8'hFE, 0, 0));
    op(8'h80, 8'h00, 8'h04, ef(8'h03, 1, 1));
    $display("test arith finished");
  endtask : t_arith
  task automatic t_incdec;
    ld(3'h7, 8'h00);
    ld(3'h1, 8'hFF);
    pre(8'h7F);
    op(8'hD6, 8'h01, 8'h07, ef(8'hFF, 0, 1));
    op(8'h0C, 8'h00, 8'h05, ef(8'h00, 1, 1));
    chk8("reg c", 8'h00, regs[15:8]);
    op(8'h0D, 8'h00, 8'h05, ef(8'hFF, 0, 1));
    chk8("reg c", 8'hFF, regs[15:8]);
    op(8'h34, 8'h00, 8'h0A, ef(8'h80, 1, 1));
    chk8("mem_we", 8'h01, {7'h00, mem_we});
    chk8("wdata", 8'h80, mem_wdata);
    op(8'h35, 8'h00, 8'h0A, ef(8'h7F, 0, 1));
    chk8("wdata", 8'h7F, mem_wdata);
    op(8'h04, 8'h00, 8'h05, ef(8'h06, 0, 1));
    chk8("reg b", 8'h06, regs[7:0]);
    $display("test incdec finished");
  endtask : t_incdec
  task automatic t_pair;
    logic [7:0] f;
    ld(3'h0, 8'h00);
    ld(3'h1, 8'h01);
    ld(3'h2, 8'h00);
    ld(3'h3, 8'h00);
    ld(3'h4, 8'hFF);
    ld(3'h5, 8'hFF);
    @(posedge mclk);
    sp_we <= 1'b1;
    sp_data <= 16'h00FF;
    @(posedge mclk);
    sp_we <= 1'b0;
    f = flags;
    op(8'h03, 8'h00, 8'h05, f);
    chk16("bc", 16'h0002, {regs[7:0], regs[15:8]});
    op(8'h1B, 8'h00, 8'h05, f);
    chk16("de", 16'hFFFF, regs[31:16]);
    op(8'h33, 8'h00, 8'h05, f);
    chk16("sp", 16'h0100, sp);
    op(8'h09, 8'h00, 8'h0A, {f[7:1], 1'b1});
    chk16("hl", 16'h0001, hl);
    op(8'h2B, 8'h00, 8'h05, {f[7:1], 1'b1});
    op(8'h29, 8'h00, 8'h0A, {f[7:1], 1'b0});
    chk16("hl", 16'h0000, hl);
    $display("test pair finished");
  endtask : t_pair
  task automatic t_daa;
    ld(3'h7, 8'h9B);
    op(8'hB7, 8'h00, 8'h04, ef(8'h9B, 0, 0));
    op(8'h27, 8'h00, 8'h04, ef(8'h01, 1, 1));
    ld(3'h7, 8'h09);
    op(8'hC6, 8'h08, 8'h07, ef(8'h11, 1, 0));
    op(8'h27, 8'h00, 8'h04, ef(8'h17, 0, 0));
    $display("test adjust finished");
  endtask : t_daa
  task automatic t_logic;
    ld(3'h7, 8'hFF);
    ld(3'h2, 8'h3C);
    op(8'hC6, 8'h01, 8'h07, ef(8'h00, 1, 1));
    ld(3'h7, 8'hF0);
    op(8'hA2, 8'h00, 8'h04, ef(8'h30, 1, 0));
    op(8'hAA, 8'h00, 8'h04, ef(8'h0C, 0, 0));
    op(8'hC6, 8'h04, 8'h07, ef(8'h10, 1, 0));
    op(8'hF6, 8'h01, 8'h07, ef(8'h11, 0, 0));
    op(8'hC6, 8'h0F, 8'h07, ef(8'h20, 1, 0));
    op(8'hE6, 8'h0F, 8'h07, ef(8'h00, 0, 0));
    pre(8'h41);
    ld(3'h7, 8'h40);
    ld(3'h3, 8'h40);
    op(8'hBB, 8'h00, 8'h04, ef(8'h00, 1, 0));
    op(8'hBE, 8'h00, 8'h07, ef(8'hFF, 0, 1));
    op(8'hFE, 8'h3F, 8'h07, ef(8'h01, 0, 0));
    chk8("acc", 8'h40, acc);
    op(8'hAE, 8'h00, 8'h07, ef(8'h01, 0, 0));
    $display("test logic finished");
  endtask : t_logic
  // requests while busy are dropped, not queued; an unknown code only pulses illegal
  task automatic t_refuse;
    int cnt;
    ld(3'h7, 8'h10);
    @(posedge mclk);
    start <= 1'b1;
    opcode <= 8'hC6;
    byte2 <= 8'h01;
    @(posedge mclk);
    ld_we <= 1'b1;
    ld_sel <= 3'h7;
    ld_data <= 8'h55;
    repeat (3) @(posedge mclk);
    start <= 1'b0;
    ld_we <= 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 20)
    begin
      @(negedge mclk);
      cnt++;
    end
    chk8("states", 8'h04, 8'(cnt));
    chk8("acc", 8'h11, acc);
    @(negedge mclk);
    chk8("done", 8'h00, {7'h00, done});
    chk8("busy", 8'h00, {7'h00, busy});
    @(posedge mclk);
    start <= 1'b1;
    opcode <= 8'h00;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    chk8("illegal", 8'h01, {7'h00, illegal});
    chk8("busy", 8'h00, {7'h00, busy});
    @(negedge mclk);
    chk8("illegal", 8'h00, {7'h00, illegal});
    chk8("acc", 8'h11, acc);
    $display("test refuse finished");
  endtask : t_refuse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // whole run is under two thousand ns; far beyond that means a hang
  initial
  begin
    #40000;
    err_total++;
    end_sim();
  end
  initial
  begin
    {rst_n, start, ld_we, sp_we, pre_we} = 5'h00;
    {opcode, byte2, ld_data, pre_data} = 32'h0000_0000;
    ld_sel = 3'h0;
    sp_data = 16'h0000;
    err_total = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_arith();
    t_incdec();
    t_pair();
    t_daa();
    t_logic();
    t_refuse();
    end_sim();
  end
endmodule : alu_core_test
